/* rtl/phy_if.sv */
// phy-side transmit, receive, collision, error count and management pins
`timescale 1ns/10ps
`include "phy_if_map.svh"
module mii_serial_phy_interface (
	input  wire logic                 clock_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 mii_mode_i,
	input  wire logic                 tx_clk_i,
	output logic [3:0]                tx_data_o,
	output logic                      tx_en_o,
	input  wire logic                 rx_clk_i,
	input  wire logic [3:0]           rx_data_i,
	input  wire logic                 rx_dv_i,
	input  wire logic                 carrier_sense_in,
	input  wire logic                 rx_err_i,
	input  wire logic                 coll_i,
	input  wire phy_if_pkg::nibble_type tx_word_i,
	input  wire logic                 tx_valid_i,
	input  wire logic                 tx_last_i,
	output logic                      tx_ready_o,
	output phy_if_pkg::nibble_type    rx_word_o,
	output logic                      rx_valid_o,
	input  wire logic                 rx_ready_i,
	output logic                      rx_frame_o,
	output logic                      coll_o,
	output logic [7:0]                sym_err_o,
	output logic                      mgmt_clock_out,
	output logic                      mdio_o,
	output logic                      mdio_oe_o,
	input  wire logic                 mdio_i,
	input  wire logic                 mgmt_dout_i,
	input  wire logic                 mgmt_drive_i,
	output logic                      mgmt_din_o
);
	import phy_if_pkg::*;

	logic       rst_m_r;
	logic       rst_r;
	logic [2:0] txc_s_r;
	logic [2:0] rxc_s_r;
	logic [3:0] rxd_m_r;
	logic [3:0] rxd_s_r;
	logic [1:0] dv_s_r;
	logic [1:0] cs_s_r;
	logic [1:0] er_s_r;
	logic [1:0] co_s_r;
	logic [1:0] md_s_r;
	logic       er_d_r;
	logic       rst_n;

	assign rst_n = rst_r;

	// reset released through two flip-flops
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_m_r <= 1'b0;
			rst_r   <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_r   <= rst_m_r;
		end
	end

	// link pins are asynchronous; two stages before any logic, third for edges
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			txc_s_r <= 3'h0;
			rxc_s_r <= 3'h0;
			rxd_m_r <= 4'h0;
			rxd_s_r <= 4'h0;
			dv_s_r  <= 2'h0;
			cs_s_r  <= 2'h0;
			er_s_r  <= 2'h0;
			co_s_r  <= 2'h0;
			md_s_r  <= 2'h0;
			er_d_r  <= 1'b0;
		end else begin
			txc_s_r <= {txc_s_r[1:0], tx_clk_i};
			rxc_s_r <= {rxc_s_r[1:0], rx_clk_i};
			rxd_m_r <= rx_data_i;
			rxd_s_r <= rxd_m_r;
			dv_s_r  <= {dv_s_r[0], rx_dv_i};
			cs_s_r  <= {cs_s_r[0], carrier_sense_in};
			er_s_r  <= {er_s_r[0], rx_err_i};
			co_s_r  <= {co_s_r[0], coll_i};
			md_s_r  <= {md_s_r[0], mdio_i};
			er_d_r  <= er_s_r[1];
		end
	end

	// a link clock idling high at reset gives one false edge; both paths are idle then, so no harm
	logic       txc_rise;
	logic       txc_fall;
	logic       rxc_rise;
	logic       rxc_fall;
	logic       tx_launch;
	logic       rx_sample;
	assign txc_rise  = txc_s_r[1] & ~txc_s_r[2];
	assign txc_fall  = ~txc_s_r[1] & txc_s_r[2];
	assign rxc_rise  = rxc_s_r[1] & ~rxc_s_r[2];
	assign rxc_fall  = ~rxc_s_r[1] & rxc_s_r[2];
	assign tx_launch = mii_mode_i ? txc_rise : txc_fall;
	assign rx_sample = mii_mode_i ? rxc_rise : rxc_fall;

	// two-entry transmit buffer: a slow link stalls the source, no word lost
	nibble_type tb_data_r [2];
	logic       tb_last_r [2];
	logic [1:0] tb_cnt_r;
	logic       tb_wp_r;
	logic       tb_rp_r;
	logic       tb_pop;
	assign tx_ready_o = (tb_cnt_r != 2'h2);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tb_cnt_r     <= 2'h0;
			tb_wp_r      <= 1'b0;
			tb_rp_r      <= 1'b0;
			tb_data_r[0] <= 4'h0;
			tb_data_r[1] <= 4'h0;
			tb_last_r[0] <= 1'b0;
			tb_last_r[1] <= 1'b0;
		end else begin
			if (tx_valid_i && tx_ready_o) begin
				tb_data_r[tb_wp_r] <= tx_word_i;
				tb_last_r[tb_wp_r] <= tx_last_i;
				tb_wp_r            <= ~tb_wp_r;
			end
			if (tb_pop)
				tb_rp_r <= ~tb_rp_r;
			tb_cnt_r <= tb_cnt_r + {1'b0, tx_valid_i && tx_ready_o} - {1'b0, tb_pop};
		end
	end

	// transmit shifter: a nibble per launch in mii mode, one bit in serial mode
	tx_state_type tx_st_r;
	nibble_type   sh_r;
	logic [2:0]   sh_left_r;
	logic         sh_last_r;
	logic [5:0]   jam_r;
	logic         coll_r;
	logic         need_word;

	assign need_word = (sh_left_r <= 3'h1);
	assign tb_pop    = tx_launch && (tx_st_r != TX_JAM) && need_word && !sh_last_r && (tb_cnt_r != 2'h0);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_r   <= TX_IDLE;
			sh_r      <= 4'h0;
			sh_left_r <= 3'h0;
			sh_last_r <= 1'b0;
			jam_r     <= 6'h0;
			tx_data_o <= 4'h0;
			tx_en_o   <= 1'b0;
		end else if (tx_launch) begin
			unique case (tx_st_r)
				TX_IDLE, TX_DATA: begin
					if (coll_r && tx_st_r == TX_DATA) begin
						tx_st_r   <= TX_JAM;
						jam_r     <= `JAM_BITS;
						tx_data_o <= `JAM_NIBBLE;
					end else if (!need_word) begin
						tx_data_o <= {3'h0, sh_r[1]};
						sh_r      <= sh_r >> 1;
						sh_left_r <= sh_left_r - 3'h1;
					end else if (tb_pop) begin
						// enable rises with the first data unit taken from the buffer
						tx_en_o   <= 1'b1;
						tx_st_r   <= TX_DATA;
						sh_r      <= tb_data_r[tb_rp_r];
						sh_last_r <= tb_last_r[tb_rp_r];
						sh_left_r <= mii_mode_i ? `SER_BITS : `NIB_BITS;
						tx_data_o <= mii_mode_i ? tb_data_r[tb_rp_r] : {3'h0, tb_data_r[tb_rp_r][0]};
					end else begin
						// enable falls once the last unit has left
						tx_en_o   <= 1'b0;
						tx_st_r   <= TX_IDLE;
						sh_last_r <= 1'b0;
						sh_left_r <= 3'h0;
						tx_data_o <= 4'h0;
					end
				end
				TX_JAM: begin
					jam_r <= jam_r - 6'h1;
					if (jam_r == 6'h1) begin
						tx_st_r   <= TX_IDLE;
						tx_en_o   <= 1'b0;
						tx_data_o <= 4'h0;
						sh_last_r <= 1'b0;
						sh_left_r <= 3'h0;
					end
				end
			endcase
		end
	end

	// collision sticky until jam ends; a new pulse wins over the clear
	logic jam_done;
	assign jam_done = tx_launch && (tx_st_r == TX_JAM) && (jam_r == 6'h1);
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n)
			coll_r <= 1'b0;
		else if (co_s_r[1])
			coll_r <= 1'b1;
		else if (jam_done)
			coll_r <= 1'b0;
	end
	assign coll_o = coll_r;

	// receive: upper lines and data valid unused in serial mode
	logic       rx_q;
	logic       rx_have_r;
	nibble_type rx_acc_r;
	logic [2:0] rx_cnt_r;
	assign rx_q = mii_mode_i ? dv_s_r[1] : cs_s_r[1];

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_acc_r   <= 4'h0;
			rx_cnt_r   <= 3'h0;
			rx_have_r  <= 1'b0;
			rx_frame_o <= 1'b0;
		end else begin
			rx_have_r <= 1'b0;
			if (rx_sample) begin
				rx_frame_o <= rx_q;
				if (!rx_q) begin
					rx_cnt_r <= 3'h0;
				end else if (mii_mode_i) begin
					rx_acc_r  <= rxd_s_r;
					rx_have_r <= 1'b1;
				end else begin
					rx_acc_r <= {rxd_s_r[0], rx_acc_r[3:1]};
					rx_cnt_r <= (rx_cnt_r == `RX_BIT_LAST) ? 3'h0 : rx_cnt_r + 3'h1;
					rx_have_r <= (rx_cnt_r == `RX_BIT_LAST);
				end
			end
		end
	end

	// two-entry receive buffer toward the user
	// a nibble that arrives with both entries full is dropped: the user must keep up
	nibble_type rb_data_r [2];
	logic [1:0] rb_cnt_r;
	logic       rb_wp_r;
	logic       rb_rp_r;
	logic       rb_push;
	logic       rb_pop;
	assign rb_push    = rx_have_r && (rb_cnt_r != 2'h2);
	assign rb_pop     = rx_valid_o && rx_ready_i;
	assign rx_valid_o = (rb_cnt_r != 2'h0);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rb_cnt_r     <= 2'h0;
			rb_wp_r      <= 1'b0;
			rb_rp_r      <= 1'b0;
			rb_data_r[0] <= 4'h0;
			rb_data_r[1] <= 4'h0;
		end else begin
			if (rb_push) begin
				rb_data_r[rb_wp_r] <= rx_acc_r;
				rb_wp_r            <= ~rb_wp_r;
			end
			if (rb_pop)
				rb_rp_r <= ~rb_rp_r;
			rb_cnt_r <= rb_cnt_r + {1'b0, rb_push} - {1'b0, rb_pop};
		end
	end
	assign rx_word_o = rb_data_r[rb_rp_r];

	// symbol error counter saturates rather than wrapping
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n)
			sym_err_o <= `SYMERR_RESET;
		else if (er_s_r[1] && !er_d_r && sym_err_o != `SYMERR_MAX)
			sym_err_o <= sym_err_o + 8'h01;
	end

	// management clock divider; data launched on the falling edge
	logic [3:0] md_div_r;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			md_div_r       <= 4'h0;
			mgmt_clock_out <= 1'b0;
			mdio_o         <= 1'b0;
			mdio_oe_o      <= 1'b0;
			mgmt_din_o     <= 1'b0;
		end else if (md_div_r == `MGMT_DIV_HALF - 4'h1) begin
			md_div_r       <= 4'h0;
			mgmt_clock_out <= ~mgmt_clock_out;
			if (mgmt_clock_out) begin
				mdio_o    <= mgmt_dout_i;
				mdio_oe_o <= mgmt_drive_i;
			end else begin
				mgmt_din_o <= md_s_r[1];
			end
		end else begin
			md_div_r <= md_div_r + 4'h1;
		end
	end
endmodule

/* rtl/phy_if_map.svh */
// constants for the phy-side media interface
`ifndef PHY_IF_MAP_SVH
`define PHY_IF_MAP_SVH
`define MGMT_DIV_HALF    4'h4
`define SYMERR_WIDTH     8
`define SYMERR_RESET     8'h00
`define SYMERR_MAX       8'hFF
`define JAM_BITS         6'h20
`define NIB_BITS         3'h4
`define SER_BITS         3'h1
`define JAM_NIBBLE       4'hF
`define RX_BIT_LAST      3'h3
`endif

/* rtl/phy_if_pkg.sv */
// types for the phy-side media interface
package phy_if_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_JAM} tx_state_type;
	typedef logic [3:0] nibble_type;
endpackage

/* sim/phy_if_assertions.sv */
// port-level checker for the phy-side media interface
`timescale 1ns/10ps
module phy_if_checker (
	input wire logic       clock_i,
	input wire logic       rst_b_i,
	input wire logic       mii_mode_i,
	input wire logic       tx_clk_i,
	input wire logic [3:0] tx_data_o,
	input wire logic       tx_en_o,
	input wire logic       coll_i,
	input wire logic       coll_o,
	input wire logic [7:0] sym_err_o,
	input wire logic       mgmt_clock_out,
	input wire logic       mdio_o
);
	logic [1:0] tsync_r;
	logic [3:0] since_r;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	// cycles since the launch edge; saturates so a stray change far from it shows
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tsync_r <= 2'h0;
			since_r <= 4'hF;
		end else begin
			tsync_r <= {tsync_r[0], tx_clk_i};
			if (tsync_r[1] != tsync_r[0] && tsync_r[0] == mii_mode_i)
				since_r <= 4'h0;
			else if (since_r != 4'hF)
				since_r <= since_r + 4'h1;
		end
	end
	sequence mgmt_hold;
		$stable(mgmt_clock_out)[*3] ##1 $changed(mgmt_clock_out);
	endsequence
	a_tx_launch_edge: assert property (($changed(tx_data_o) || $changed(tx_en_o)) |-> since_r <= 4'h6)
		else $error("tx pins moved away from launch edge");
	a_jam_nibble: assert property ((coll_o && $past(coll_o) && tx_en_o && $changed(tx_data_o))
		|-> tx_data_o == 4'hF)
		else $error("jam nibble wrong");
	a_coll_set: assert property (($rose(coll_i) && tx_en_o) |-> ##[1:6] coll_o)
		else $error("collision not flagged");
	a_coll_clear: assert property ($fell(coll_o) |-> !tx_en_o)
		else $error("collision cleared mid frame");
	a_symerr_step: assert property ($changed(sym_err_o) |-> sym_err_o == $past(sym_err_o) + 8'h01)
		else $error("symbol count not stepping by one");
	a_symerr_sat: assert property (sym_err_o == 8'hFF |=> sym_err_o == 8'hFF)
		else $error("symbol count wrapped");
	a_mgmt_period: assert property ($changed(mgmt_clock_out) |-> ##1 mgmt_hold)
		else $error("management clock half period wrong");
	a_mdio_launch: assert property ($changed(mdio_o) |-> !mgmt_clock_out)
		else $error("mdio changed while management clock high");
endmodule
bind mii_serial_phy_interface phy_if_checker u_phy_if_checker (.clock_i(clock_i), .rst_b_i(rst_b_i),
	.mii_mode_i(mii_mode_i), .tx_clk_i(tx_clk_i), .tx_data_o(tx_data_o), .tx_en_o(tx_en_o), .coll_i(coll_i),
	.coll_o(coll_o), .sym_err_o(sym_err_o), .mgmt_clock_out(mgmt_clock_out), .mdio_o(mdio_o));

/* sim/phy_model.sv */
// link-side model: free running link clocks and receive traffic
`timescale 1ns/10ps
module phy_model (
	input  wire logic mii_mode_i,
	output logic       tx_clk_o,
	output logic       rx_clk_o,
	output logic [3:0] rx_data_o,
	output logic       rx_dv_o,
	output logic       carrier_o
);
	initial begin
		tx_clk_o = 1'b0;
		rx_data_o = 4'h0;
		rx_dv_o = 1'b0;
		carrier_o = 1'b0;
		forever #400 tx_clk_o = ~tx_clk_o;
	end
	// odd offset keeps the receive clock unrelated in phase to the others
	initial begin
		rx_clk_o = 1'b0;
		#137;
		forever #400 rx_clk_o = ~rx_clk_o;
	end
	task automatic send_byte(input logic [7:0] b);
		if (mii_mode_i) begin
			for (int i = 0; i < 2; i++) begin
				@(negedge rx_clk_o);
				rx_data_o = b[i*4 +: 4];
				rx_dv_o = 1'b1;
				carrier_o = 1'b1;
			end
			@(negedge rx_clk_o);
			rx_dv_o = 1'b0;
			carrier_o = 1'b0;
			rx_data_o = ~rx_data_o;
		end else begin
			rx_dv_o = 1'b1;
			for (int i = 0; i < 8; i++) begin
				@(posedge rx_clk_o);
				rx_data_o = {3'h5, b[i]};
				carrier_o = 1'b1;
			end
			@(posedge rx_clk_o);
			carrier_o = 1'b0;
			rx_data_o[0] = ~rx_data_o[0];
			rx_dv_o = 1'b0;
		end
	endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the phy-side media interface
`timescale 1ns/10ps
module testbench;
	logic clock_i, rst_b_i, mii_mode_i, rx_err_i, coll_i, tx_valid_i, tx_last_i, rx_ready_i;
	logic mgmt_dout_i, mgmt_drive_i, phy_md, tx_en_o, tx_ready_o, rx_valid_o, rx_frame_o, coll_o;
	logic mgmt_clock_out, mdio_o, mdio_oe_o, mgmt_din_o;
	logic [3:0] tx_word_i, tx_data_o, rx_word_o;
	logic [7:0] sym_err_o;
	wire tx_clk_i, rx_clk_i, rx_dv_i, carrier_sense_in, mdio_i;
	wire [3:0] rx_data_i;
	int failures, num_checks, cycles;
	assign mdio_i = mdio_oe_o ? mdio_o : phy_md;
	mii_serial_phy_interface u_mii_serial_phy_interface (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.mii_mode_i(mii_mode_i), .tx_clk_i(tx_clk_i), .tx_data_o(tx_data_o), .tx_en_o(tx_en_o),
		.rx_clk_i(rx_clk_i), .rx_data_i(rx_data_i), .rx_dv_i(rx_dv_i), .carrier_sense_in(carrier_sense_in),
		.rx_err_i(rx_err_i), .coll_i(coll_i), .tx_word_i(tx_word_i), .tx_valid_i(tx_valid_i),
		.tx_last_i(tx_last_i), .tx_ready_o(tx_ready_o), .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o),
		.rx_ready_i(rx_ready_i), .rx_frame_o(rx_frame_o), .coll_o(coll_o), .sym_err_o(sym_err_o),
		.mgmt_clock_out(mgmt_clock_out), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .mdio_i(mdio_i),
		.mgmt_dout_i(mgmt_dout_i), .mgmt_drive_i(mgmt_drive_i), .mgmt_din_o(mgmt_din_o));
	phy_model u_phy_model (.mii_mode_i(mii_mode_i), .tx_clk_o(tx_clk_i), .rx_clk_o(rx_clk_i),
		.rx_data_o(rx_data_i), .rx_dv_o(rx_dv_i), .carrier_o(carrier_sense_in));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// five cycles lets the synchronised launch land, well before the next one
	task automatic wait_launch;
		if (mii_mode_i) @(posedge tx_clk_i);
		else @(negedge tx_clk_i);
		repeat (5) @(negedge clock_i);
	endtask
	task automatic push(input logic [3:0] w, input logic last);
		tx_word_i = w;
		tx_last_i = last;
		tx_valid_i = 1'b1;
		while (tx_ready_o !== 1'b1) @(negedge clock_i);
		@(negedge clock_i);
	endtask
	task automatic tx_frame(input logic mode);
		logic [3:0] w [3];
		w = '{4'hA, 4'h6, 4'h3};
		mii_mode_i = mode;
		wait_launch;
		push(w[0], 1'b0);
		push(w[1], 1'b0);
		tx_valid_i = 1'b0;
		check("tx ready", 8'h00, tx_ready_o);
		for (int i = 0; i < 3; i++) begin
			for (int b = 0; b < (mode ? 1 : 4); b++) begin
				wait_launch;
				check("tx en", 8'h01, tx_en_o);
				if (mode) check("tx nibble", w[i], tx_data_o);
				else check("tx bit", w[i][b], tx_data_o[0]);
			end
			if (i == 0) begin
				push(w[2], 1'b1);
				tx_valid_i = 1'b0;
			end
		end
		wait_launch;
		check("tx en end", 8'h00, tx_en_o);
	endtask
	task automatic collide;
		int n;
		n = 0;
		mii_mode_i = 1'b1;
		wait_launch;
		push(4'h9, 1'b1);
		tx_valid_i = 1'b0;
		wait_launch;
		coll_i = 1'b1;
		repeat (2) @(negedge clock_i);
		coll_i = 1'b0;
		for (int k = 0; k < 40; k++) begin
			wait_launch;
			if (k == 0) check("coll set", 8'h01, coll_o);
			if (tx_en_o === 1'b1 && tx_data_o === 4'hF) n++;
		end
		check("jam launches", 8'h20, n[7:0]);
		check("coll clear", 8'h00, coll_o);
	endtask
	task automatic pop(input logic [3:0] exp);
		check("rx valid", 8'h01, rx_valid_o);
		check("rx word", exp, rx_word_o);
		rx_ready_i = 1'b1;
		@(negedge clock_i);
		rx_ready_i = 1'b0;
		@(negedge clock_i);
	endtask
	task automatic rx_byte(input logic mode, input logic [7:0] b);
		mii_mode_i = mode;
		u_phy_model.send_byte(b);
		@(negedge clock_i);
		check("rx frame on", 8'h01, rx_frame_o);
		repeat (12) @(negedge clock_i);
		check("rx frame off", 8'h00, rx_frame_o);
		pop(b[3:0]);
		pop(b[7:4]);
		check("rx empty", 8'h00, rx_valid_o);
	endtask
	task automatic sym_errors;
		for (int k = 0; k < 258; k++) begin
			rx_err_i = 1'b1;
			repeat (3) @(negedge clock_i);
			rx_err_i = 1'b0;
			repeat (3) @(negedge clock_i);
			if (k == 2) check("sym count", 8'h03, sym_err_o);
		end
		check("sym saturate", 8'hFF, sym_err_o);
	endtask
	task automatic mgmt;
		mgmt_drive_i = 1'b1;
		repeat (20) @(negedge clock_i);
		check("mdio oe", 8'h01, mdio_oe_o);
		check("mdio high", 8'h01, mdio_o);
		mgmt_dout_i = 1'b0;
		repeat (20) @(negedge clock_i);
		check("mdio low", 8'h00, mdio_o);
		mgmt_drive_i = 1'b0;
		phy_md = 1'b1;
		repeat (20) @(negedge clock_i);
		check("mdio off", 8'h00, mdio_oe_o);
		check("mdio in high", 8'h01, mgmt_din_o);
		phy_md = 1'b0;
		repeat (20) @(negedge clock_i);
		check("mdio in low", 8'h00, mgmt_din_o);
	endtask
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		cycles = 0;
		forever begin
			@(posedge clock_i);
			cycles++;
			if (cycles == 20000) begin
				failures++;
				end_of_test;
			end
		end
	end
	initial begin
		{rst_b_i, rx_err_i, coll_i, tx_valid_i, tx_last_i, rx_ready_i, mgmt_drive_i} = 7'h00;
		{mii_mode_i, mgmt_dout_i, phy_md} = 3'h7;
		tx_word_i = 4'h0;
		failures = 0;
		num_checks = 0;
		repeat (8) @(negedge clock_i);
		rst_b_i = 1'b1;
		repeat (3) @(negedge clock_i);
		tx_frame(1'b1);
		tx_frame(1'b0);
		collide;
		rx_byte(1'b1, 8'hC5);
		rx_byte(1'b0, 8'h3A);
		sym_errors;
		mgmt;
		end_of_test;
	end
endmodule
